/* core/motor_pwm_pkg.sv */
// Package with register map, field layouts, reset values and timing counts of the PWM mode control.
package motor_pwm_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_DUTY   = 8'h04;
  localparam logic [7:0] OFF_ADC    = 8'h08;
  localparam logic [7:0] OFF_DESIRE = 8'h0c;
  localparam logic [7:0] OFF_UPDATE = 8'h10;
  localparam logic [7:0] OFF_STEP   = 8'h14;
  localparam logic [7:0] OFF_FREQ   = 8'h18;
  localparam logic [7:0] OFF_DEAD   = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;

  // Operating mode codes held in the mode register.
  localparam logic [2:0] MODE_SERIAL = 3'h0;
  localparam logic [2:0] MODE_UNI    = 3'h1;
  localparam logic [2:0] MODE_BI     = 3'h2;
  localparam logic [2:0] MODE_SPEED  = 3'h3;
  localparam logic [2:0] MODE_TABLE  = 3'h4;

  // Duty word layout: bit 10 is direction (1 = reverse), bits 9:0 magnitude.
  localparam int DUTY_W   = 10;
  localparam int DIR_BIT  = 10;
  localparam logic [9:0] DUTY_MAX  = 10'h3ff;
  localparam logic [9:0] HALF_CODE = 10'h200;

  // Reset values.
  localparam logic [7:0] UPDATE_RST = 8'h01;
  localparam logic [7:0] STEP_RST   = 8'hff;
  localparam logic [1:0] FREQ_RST   = 2'h0;
  localparam logic [7:0] DEAD_RST   = 8'h00;

  // Timing: one duty update spans 16 PWM periods; the 833 us target gives about 786 us by default, as TICK_CYCLES truncates to 12.
  localparam int PERIODS_PER_UPDATE = 16;
  localparam int UPDATE_US          = 833;
  localparam int CLK_MHZ            = 250;
  // Base PWM period at frequency select 0: 1024 counts of a prescaled tick.
  localparam int PERIOD_NS          = (UPDATE_US * 1000) / PERIODS_PER_UPDATE;
  localparam int PERIOD_CYCLES      = (PERIOD_NS * CLK_MHZ) / 1000;
  localparam int TICK_CYCLES        = PERIOD_CYCLES / 1024;

endpackage

/* core/motor_pwm_mode_control.sv */
// Mode-selected duty setpoint generator with slew limit, update pacing and PWM output.
//
// Notes on behaviour
// R1 - Five operating modes chosen by bits of the mode-select register.
// R2 - After reset serial mode; duty and direction come from set-duty command writes.
// R3 - Uni-directional analog mode uses ADC code as duty; 0x200 gives 50 percent.
// R4 - ADC full scale is 4.096 V, so half voltage is code 512.
// R5 - By default the applied duty is recomputed every 16 PWM periods.
// R6 - The update-interval multiplier lengthens the update spacing; 1 means default.
// R7 - Each update moves the applied duty by at most the slew limit, up to 255.
// R8 - Frequency select sets PWM carrier; higher frequency gives fewer resolution bits.
// R9 - Analog setpoint passes resolution, interval, slew and neutral zone before loading.
// R10 - Speed mode compares measured ADC value with the desired value register.
// R11 - Master should set slew 1 and raise interval for smooth speed control.
// R12 - Low stop request clears the duty register.
// R13 - Setpoint held within 0 to 1023 and reduced to selected resolution; speed mode nudges by one count without the reduction.
`timescale 1ns/1ps
module motor_pwm_mode_control #(
  parameter int TICK_DIV = motor_pwm_pkg::TICK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [9:0]  adc_code,
  input  wire logic        stop_n,
  output logic             pwm_out,
  output logic             dir_out
);

  typedef struct packed {
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [2:0]  mode;
    logic [10:0] cmd_duty;
    logic [10:0] duty;
    logic [9:0]  desire;
    logic [7:0]  upd_mult;
    logic [7:0]  step;
    logic [1:0]  freq;
    logic [7:0]  dead;
    logic [31:0] rdata;
    logic [15:0] tick_cnt;
    logic [9:0]  pwm_cnt;
    logic [3:0]  per_cnt;
    logic [7:0]  mult_cnt;
    logic        pwm;
    logic        dir;
    logic        upd_pulse;
    logic [9:0]  adc_s1;
    logic [9:0]  adc_s2;
    logic [9:0]  adc_s3;
    logic [9:0]  adc_val;
    logic        stop_s1;
    logic        stop_s2;
  } state_s;

  state_s q, d;

  logic        addr_ok;
  logic [9:0]  res_mask;
  logic [9:0]  period_top;
  logic [10:0] target;
  logic [11:0] tmag;
  logic [11:0] cur;
  logic [11:0] diff;
  logic [11:0] next_s;
  logic [10:0] bi_val;
  logic [7:0]  eff_step;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q.rdata;
  assign pwm_out   = q.pwm;
  assign dir_out   = q.dir;
  assign addr_ok   = hsel && hready && htrans[1];

  always_comb begin
    // Each frequency step halves the counter length and drops one low duty bit.
    period_top = motor_pwm_pkg::DUTY_MAX >> q.freq; // R8
    res_mask   = motor_pwm_pkg::DUTY_MAX << q.freq; // R13
  end

  always_comb begin
    tmag   = '0;
    bi_val = '0;
    target = q.duty;
    cur    = '0;
    diff   = '0;
    next_s = '0;
    case (q.mode) // R1
      motor_pwm_pkg::MODE_UNI,
      motor_pwm_pkg::MODE_TABLE: begin
        // The table holds its identity profile, so it matches the uni mode.
        target = {1'b0, q.adc_val & res_mask}; // R3 R4 R13
      end
      motor_pwm_pkg::MODE_BI: begin
        if (q.adc_val >= motor_pwm_pkg::HALF_CODE) begin
          bi_val = {1'b0, (q.adc_val - motor_pwm_pkg::HALF_CODE) << 1};
        end else begin
          bi_val = {1'b1, (motor_pwm_pkg::HALF_CODE - q.adc_val) << 1};
          if (bi_val[9:0] == 10'h000) begin
            bi_val[9:0] = motor_pwm_pkg::DUTY_MAX;
          end
        end
        target = {bi_val[10], bi_val[9:0] & res_mask}; // R13
      end
      motor_pwm_pkg::MODE_SPEED: begin
        // A fixed one-step nudge toward the desired reading, no filtering.
        target = q.duty;
        if (q.adc_val < q.desire && q.duty[9:0] != motor_pwm_pkg::DUTY_MAX) begin // R10
          target = {1'b0, q.duty[9:0] + 10'h001};
        end else if (q.adc_val > q.desire && q.duty[9:0] != 10'h000) begin // R10
          target = {1'b0, q.duty[9:0] - 10'h001};
        end
      end
      default: target = q.cmd_duty; // R2
    endcase
    // Neutral zone: small analog demands become zero duty.
    if (q.mode != motor_pwm_pkg::MODE_SERIAL && {2'b00, target[9:0]} <= {4'h0, q.dead}) begin
      target = '0; // R9
    end
    // Signed arithmetic on magnitude with direction gives smooth reversal.
    tmag   = target[10] ? 12'(-$signed({2'b00, target[9:0]})) : {2'b00, target[9:0]};
    cur    = q.duty[10] ? 12'(-$signed({2'b00, q.duty[9:0]})) : {2'b00, q.duty[9:0]};
    diff   = 12'(tmag - cur);
    // Outside speed mode the step is cut to the duty granule, so a ramp never leaves the
    // selected resolution; a step below one granule then stalls the ramp there.
    eff_step = (q.mode == motor_pwm_pkg::MODE_SPEED) ? q.step : (q.step & res_mask[7:0]); // R13
    if (!diff[11] && diff > {4'h0, q.step}) begin
      next_s = 12'(cur + {4'h0, eff_step}); // R7
    end else if (diff[11] && 12'(-diff) > {4'h0, q.step}) begin
      next_s = 12'(cur - {4'h0, eff_step}); // R7
    end else begin
      next_s = tmag;
    end
  end

  always_comb begin
    d           = q;
    d.upd_pulse = 1'b0;
    d.adc_s1    = adc_code;
    d.adc_s2    = q.adc_s1;
    d.stop_s1   = stop_n;
    d.stop_s2   = q.stop_s1;
    // The ADC bits may settle at different edges; a word is taken only once it stood
    // unchanged for two cycles, so a torn code never reaches the duty logic.
    d.adc_s3    = q.adc_s2;
    d.adc_val   = (q.adc_s2 == q.adc_s3) ? q.adc_s3 : q.adc_val;
    // Bus write data arrives one cycle after its address phase.
    d.wr_pend   = addr_ok && hwrite;
    d.wr_addr   = haddr;
    if (q.wr_pend) begin
      case (q.wr_addr)
        motor_pwm_pkg::OFF_MODE:   d.mode     = hwdata[2:0] > motor_pwm_pkg::MODE_TABLE ?
                                                q.mode : hwdata[2:0]; // R1
        motor_pwm_pkg::OFF_DUTY:   d.cmd_duty = {hwdata[motor_pwm_pkg::DIR_BIT],
                                                 hwdata[9:0] & res_mask}; // R2 R13
        motor_pwm_pkg::OFF_DESIRE: d.desire   = hwdata[9:0]; // R10
        motor_pwm_pkg::OFF_UPDATE: d.upd_mult = hwdata[7:0] == 8'h00 ? 8'h01 : hwdata[7:0];
        motor_pwm_pkg::OFF_STEP:   d.step     = hwdata[7:0]; // R7
        motor_pwm_pkg::OFF_FREQ:   d.freq     = hwdata[1:0]; // R8
        motor_pwm_pkg::OFF_DEAD:   d.dead     = hwdata[7:0]; // R9
        default: ;
      endcase
    end
    // Mode, desire, update, step, freq and dead reads look at the next state, so a read right behind a write sees the new value.
    if (addr_ok && !hwrite) begin
      case (haddr)
        motor_pwm_pkg::OFF_MODE:   d.rdata = {29'h0, d.mode};
        motor_pwm_pkg::OFF_DUTY:   d.rdata = {21'h0, q.duty};
        motor_pwm_pkg::OFF_ADC:    d.rdata = {22'h0, q.adc_val};
        motor_pwm_pkg::OFF_DESIRE: d.rdata = {22'h0, d.desire};
        motor_pwm_pkg::OFF_UPDATE: d.rdata = {24'h0, d.upd_mult};
        motor_pwm_pkg::OFF_STEP:   d.rdata = {24'h0, d.step};
        motor_pwm_pkg::OFF_FREQ:   d.rdata = {30'h0, d.freq};
        motor_pwm_pkg::OFF_DEAD:   d.rdata = {24'h0, d.dead};
        motor_pwm_pkg::OFF_STATUS: d.rdata = {30'h0, ~q.stop_s2, q.dir};
        default:                   d.rdata = 32'h0;
      endcase
    end
    // PWM carrier: prescaled tick, counter wraps at the frequency-dependent top.
    if (q.tick_cnt >= 16'(TICK_DIV - 1)) begin
      d.tick_cnt = '0;
      if (q.pwm_cnt >= period_top) begin // R8
        d.pwm_cnt = '0;
        d.per_cnt = 4'(q.per_cnt + 4'h1);
        if (q.per_cnt == 4'(motor_pwm_pkg::PERIODS_PER_UPDATE - 1)) begin // R5
          if (q.mult_cnt + 8'h01 >= q.upd_mult) begin // R6
            d.mult_cnt  = '0;
            d.upd_pulse = 1'b1;
          end else begin
            d.mult_cnt = 8'(q.mult_cnt + 8'h01);
          end
        end
      end else begin
        d.pwm_cnt = 10'(q.pwm_cnt + 10'h001);
      end
    end else begin
      d.tick_cnt = 16'(q.tick_cnt + 16'h0001);
    end
    if (q.upd_pulse) begin
      // Serial writes are slewed too, which keeps the bridge from abrupt steps.
      d.duty = {next_s[11], next_s[11] ? 10'(-next_s) : next_s[9:0]}; // R5 R9
    end
    d.pwm = (q.duty[9:0] >> q.freq) > q.pwm_cnt;
    d.dir = q.duty[motor_pwm_pkg::DIR_BIT];
    if (!q.stop_s2) begin
      d.duty     = '0; // R12
      d.cmd_duty = '0; // R12
      d.pwm      = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.mode     <= motor_pwm_pkg::MODE_SERIAL; // R2
      q.upd_mult <= motor_pwm_pkg::UPDATE_RST;
      q.step     <= motor_pwm_pkg::STEP_RST;
      q.freq     <= motor_pwm_pkg::FREQ_RST;
      q.dead     <= motor_pwm_pkg::DEAD_RST;
      q.stop_s1  <= 1'b1;
      q.stop_s2  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  a_stop_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.stop_s2 |=> q.duty == 11'h000) else $error("duty not cleared by stop"); // R12
  a_slew_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.upd_pulse && q.stop_s2 && !q.duty[10] && !next_s[11]) |=>
    ({1'b0, q.duty[9:0]} <= {1'b0, $past(q.duty[9:0])} + {3'b000, $past(q.step)} &&
     {1'b0, q.duty[9:0]} + {3'b000, $past(q.step)} >= {1'b0, $past(q.duty[9:0])}))
    else $error("duty moved more than step"); // R7
  a_duty_steady: assert property (@(posedge hclk) disable iff (!hresetn)
    (!q.upd_pulse && q.stop_s2) |=> $stable(q.duty)) else $error("duty changed off update"); // R5
  a_mode_legal: assert property (@(posedge hclk) disable iff (!hresetn)
    q.mode <= motor_pwm_pkg::MODE_TABLE) else $error("illegal mode"); // R1
  a_uni_target: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.mode == motor_pwm_pkg::MODE_UNI && (q.adc_val & res_mask) > {2'b00, q.dead}) |->
    target == {1'b0, q.adc_val & res_mask}) else $error("uni target wrong"); // R3
  a_range_res: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.duty[9:0] & ~res_mask) == 10'h000 || q.mode == motor_pwm_pkg::MODE_SPEED)
    else $error("duty below resolution"); // R13
  a_serial_src: assert property (@(posedge hclk) disable iff (!hresetn)
    q.mode == motor_pwm_pkg::MODE_SERIAL |-> target == q.cmd_duty)
    else $error("serial target wrong"); // R2
  a_speed_dir: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.mode == motor_pwm_pkg::MODE_SPEED && q.adc_val < q.desire && q.duty[9:0] < 10'h3fe
     && q.duty[9:0] > {2'b00, q.dead}) |-> target[9:0] == q.duty[9:0] + 10'h001)
    else $error("speed nudge wrong"); // R10
  a_period_top: assert property (@(posedge hclk) disable iff (!hresetn)
    q.pwm_cnt <= period_top || $changed(q.freq) || $past(q.freq) != q.freq)
    else $error("pwm counter past top"); // R8
  a_pulse_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    q.upd_pulse |=> !q.upd_pulse) else $error("update pulses adjacent"); // R6

  // Bus side: zero wait states, always OKAY, and read data held between reads.
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not ready and okay");

  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(addr_ok && !hwrite) |=> $stable(q.rdata))
    else $error("read data changed without a read");

  a_mode_write: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (q.wr_pend && q.wr_addr == motor_pwm_pkg::OFF_MODE &&
     hwdata[2:0] <= motor_pwm_pkg::MODE_TABLE) |=> q.mode == $past(hwdata[2:0]))
    else $error("mode write lost");

  a_cmd_res: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    (q.wr_pend && q.wr_addr == motor_pwm_pkg::OFF_DUTY) |=>
    (q.cmd_duty[9:0] & ~$past(res_mask)) == 10'h000)
    else $error("set-duty value below resolution");

  a_step_write: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    (q.wr_pend && q.wr_addr == motor_pwm_pkg::OFF_STEP) |=> q.step == $past(hwdata[7:0]))
    else $error("step write lost");

  a_freq_write: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (q.wr_pend && q.wr_addr == motor_pwm_pkg::OFF_FREQ) |=> q.freq == $past(hwdata[1:0]))
    else $error("frequency write lost");

  a_desire_write: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (q.wr_pend && q.wr_addr == motor_pwm_pkg::OFF_DESIRE) |=>
    q.desire == $past(hwdata[9:0]))
    else $error("desired value write lost");

  a_dead_write: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    (q.wr_pend && q.wr_addr == motor_pwm_pkg::OFF_DEAD) |=> q.dead == $past(hwdata[7:0]))
    else $error("dead band write lost");

  a_update_write: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (q.wr_pend && q.wr_addr == motor_pwm_pkg::OFF_UPDATE && hwdata[7:0] != 8'h00) |=>
    q.upd_mult == $past(hwdata[7:0]))
    else $error("update multiplier write lost");

  a_mult_nonzero: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    q.upd_mult != 8'h00)
    else $error("update multiplier zero");

  a_mult_reset: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    q.upd_pulse |-> q.mult_cnt == 8'h00)
    else $error("multiplier count not restarted");

  a_pulse_wrap: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    q.upd_pulse |-> q.per_cnt == 4'h0 && q.pwm_cnt == 10'h000)
    else $error("update pulse off period boundary");

  // Stop must silence the bridge and drop any pending set-duty value.
  a_stop_pwm: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    !q.stop_s2 |=> !q.pwm)
    else $error("pwm active during stop");

  a_stop_cmd: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    !q.stop_s2 |=> q.cmd_duty == 11'h000)
    else $error("set-duty value kept during stop");

  a_dir_follow: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    1'b1 |=> q.dir == $past(q.duty[10]))
    else $error("direction not following duty");

  a_zero_low: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    q.duty[9:0] == 10'h000 |=> !q.pwm)
    else $error("pwm high at zero duty");

  a_slew_reverse: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    (q.upd_pulse && q.stop_s2 && q.duty[10] && next_s[11]) |=>
    ({1'b0, q.duty[9:0]} <= {1'b0, $past(q.duty[9:0])} + {3'b000, $past(q.step)} &&
     {1'b0, q.duty[9:0]} + {3'b000, $past(q.step)} >= {1'b0, $past(q.duty[9:0])}))
    else $error("reverse duty moved more than step");

  a_speed_down: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (q.mode == motor_pwm_pkg::MODE_SPEED && q.adc_val > q.desire &&
     q.duty[9:0] > {2'b00, q.dead} + 10'h001) |-> target[9:0] == q.duty[9:0] - 10'h001)
    else $error("speed nudge down wrong");

  a_speed_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    (q.mode == motor_pwm_pkg::MODE_SPEED && q.adc_val == q.desire &&
     q.duty[9:0] > {2'b00, q.dead}) |-> target == q.duty)
    else $error("speed target moved at set point");

  a_dead_zero: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    (q.mode == motor_pwm_pkg::MODE_UNI &&
     {2'b00, q.adc_val & res_mask} <= {4'h0, q.dead}) |-> target == 11'h000)
    else $error("neutral zone not applied");

  a_adc_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    q.adc_s2 != q.adc_s3 |=> $stable(q.adc_val))
    else $error("unsettled adc word taken");

endmodule // motor_pwm_mode_control

/* verif/motor_far_side.sv */
// Far-side model: control voltage source with ADC and stop switch; pwm_out is taken but not used.
`timescale 1ns/1ps
module motor_far_side (
  input  wire logic        hclk,
  input  wire logic [12:0] volt_mv,
  input  wire logic        brake_req,
  input  wire logic        pwm_out,
  output logic      [9:0]  adc_code,
  output logic             stop_n
);
  // Full scale is 4096 mV, so one code step is 4 mV and 2048 mV reads 0x200.
  always @(posedge hclk) begin
    adc_code <= (volt_mv >= 13'h1000) ? 10'h3ff : volt_mv[11:2];
    stop_n   <= !brake_req;
  end
  initial begin
    adc_code = 10'h000;
    stop_n   = 1'b1;
  end
endmodule // motor_far_side

/* verif/tb_top.sv */
// Self-checking bench for the PWM mode control block.
`timescale 1ns/1ps
module tb_top;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, brake_req = 0;
  logic        hreadyout, hresp, pwm_out, dir_out, stop_n;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, v, w;
  logic [12:0] volt_mv = 13'h0;
  logic [9:0]  adc_code;
  int          n_fail = 0, cmp_count = 0, cyc = 0, t0, t1, c;
  // One period per update at select 3 is 128 counts, so 16 periods take 2048 cycles.
  localparam int UPD = 2048;
  localparam logic [7:0]  RA [7] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24};
  localparam logic [31:0] RV [7] = '{32'h0, 32'h0, 32'h1, 32'hff, 32'h0, 32'h0, 32'h0};
  motor_pwm_mode_control #(.TICK_DIV(1)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .adc_code(adc_code), .stop_n(stop_n), .pwm_out(pwm_out), .dir_out(dir_out));
  motor_far_side far (.hclk(hclk), .volt_mv(volt_mv), .brake_req(brake_req),
    .pwm_out(pwm_out), .adc_code(adc_code), .stop_n(stop_n));
  initial begin
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;
  function automatic logic [31:0] exp_code(input logic [12:0] mv);
    return (mv >= 13'h1000) ? 32'h3ff : 32'(mv[11:2]);
  endfunction
  // Bi-directional mapping: twice the distance from half scale, bit 10 marks reverse.
  function automatic logic [31:0] exp_bi(input logic [12:0] mv);
    logic [31:0] a;
    a = exp_code(mv);
    if (a >= 32'h200) return (a - 32'h200) << 1;
    return 32'h400 | ((32'h200 - a) << 1);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask
  // Polls the applied duty until it moves and stamps the cycle it was seen.
  task automatic poll(input logic [31:0] prev, output logic [31:0] d, output int t);
    int i;
    i = 0;
    d = prev;
    while (d === prev && i < 3000) begin
      rd(motor_pwm_pkg::OFF_DUTY, d);
      i++;
    end
    t = cyc;
  endtask
  task automatic count_on(input int n, output int k);
    k = 0;
    repeat (n) @(posedge hclk) k += (pwm_out === 1'b1);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #396000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h6bfc));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(RA[i], v);
      chk(v, RV[i]);
    end
    for (int m = 0; m < 5; m++) begin
      wr(motor_pwm_pkg::OFF_MODE, 32'(m));
      rd(motor_pwm_pkg::OFF_MODE, v);
      chk(v, 32'(m));
    end
    wr(motor_pwm_pkg::OFF_MODE, 32'h5);
    rd(motor_pwm_pkg::OFF_MODE, v);
    chk(v, 32'(motor_pwm_pkg::MODE_TABLE));
    wr(motor_pwm_pkg::OFF_MODE, 32'(motor_pwm_pkg::MODE_SERIAL));
    wr(motor_pwm_pkg::OFF_FREQ, 32'h3);
    wr(motor_pwm_pkg::OFF_STEP, 32'h10);
    wr(motor_pwm_pkg::OFF_DUTY, 32'h100);
    poll(32'h0, v, t0);
    chk(v, 32'h10);
    poll(v, w, t1);
    chk(w, 32'h20);
    chk(32'(t1 - t0 <= UPD + 4 && t1 - t0 >= UPD - 4), 32'h1);
    wr(motor_pwm_pkg::OFF_UPDATE, 32'h2);
    poll(w, v, t0);
    poll(v, w, t1);
    chk(32'(t1 - t0 <= 2 * UPD + 4 && t1 - t0 >= 2 * UPD - 4), 32'h1);
    wr(motor_pwm_pkg::OFF_UPDATE, 32'h1);
    wr(motor_pwm_pkg::OFF_STEP, 32'hff);
    wr(motor_pwm_pkg::OFF_MODE, 32'(motor_pwm_pkg::MODE_UNI));
    for (int k = 0; k < 4; k++) begin
      volt_mv <= (k == 3) ? 13'd2048 : 13'(($urandom % 128) * 32);
      repeat (6 * UPD) @(posedge hclk);
      rd(motor_pwm_pkg::OFF_DUTY, v);
      chk(v, exp_code(volt_mv));
    end
    count_on(128, c);
    chk(32'(c), 32'd64);
    wr(motor_pwm_pkg::OFF_FREQ, 32'h2);
    repeat (4 * UPD) @(posedge hclk);
    count_on(256, c);
    chk(32'(c), 32'd128);
    brake_req <= 1'b1;
    repeat (8) @(posedge hclk);
    rd(motor_pwm_pkg::OFF_DUTY, v);
    chk(v, 32'h0);
    count_on(256, c);
    chk(32'(c), 32'd0);
    brake_req <= 1'b0;
    wr(motor_pwm_pkg::OFF_MODE, 32'(motor_pwm_pkg::MODE_BI));
    volt_mv <= 13'd1536;
    repeat (7 * UPD) @(posedge hclk);
    rd(motor_pwm_pkg::OFF_DUTY, v);
    chk(v, exp_bi(13'd1536));
    chk(32'(dir_out), 32'h1);
    chk(32'(hresp), 32'h0);
    wr(motor_pwm_pkg::OFF_FREQ, 32'h3);
    wr(motor_pwm_pkg::OFF_STEP, 32'h1);
    wr(motor_pwm_pkg::OFF_UPDATE, 32'h2);
    wr(motor_pwm_pkg::OFF_DESIRE, 32'h3ff);
    wr(motor_pwm_pkg::OFF_MODE, 32'(motor_pwm_pkg::MODE_SPEED));
    poll(v, w, t0);
    chk(w, 32'h4ff);
    report_and_stop();
  end
endmodule // tb_top
